// ==== port_mux_params.svh ====
// Constants for the port E / port F alternate function mux
`ifndef PORT_MUX_PARAMS_SVH
`define PORT_MUX_PARAMS_SVH
`define PORT_WIDTH        8
`define PE_RXD_BIT        0
`define PE_TXD_BIT        1
`define PE_USART_CLK_BIT  2
`define PE_AIN1_BIT       3
`define PE_SCL_BIT        4
`define PE_SDA_BIT        5
`define PE_DO_BIT         6
`define PE_CLK_OUT_BIT    7
`define PF_TCK_BIT        4
`define PF_TMS_BIT        5
`define PF_TDO_BIT        6
`define PF_TDI_BIT        7
`define CLK_DIV_RESET     8'h00
`endif

// ==== port_mux_pkg.sv ====
// Types shared by the port override mux
package port_mux_pkg;
   // One override group per pin set
   typedef struct packed {
      logic [7:0] pullup_override_enable;
      logic [7:0] pullup_override_value;
      logic [7:0] dir_override_enable;
      logic [7:0] dir_override_value;
      logic [7:0] outval_override_enable;
      logic [7:0] outval_override_value;
      logic [7:0] input_en_override_enable;
      logic [7:0] input_en_override_value;
   } override_t;
   // Normal port settings of one port
   typedef struct packed {
      logic [7:0] out_bits;
      logic [7:0] dir_bits;
   } port_cfg_t;
endpackage : port_mux_pkg

// ==== pin_override.sv ====
// Per-bit override selection of one eight bit port
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_params.svh"
module pin_override
   import port_mux_pkg::*;
#(
   parameter int WIDTH = `PORT_WIDTH
)
(
   // Normal settings
   input  wire logic [WIDTH-1:0] out_bits_i,
   input  wire logic [WIDTH-1:0] dir_bits_i,
   input  wire logic             global_pullup_disable_i,
   // Overrides
   input  wire override_t        ovr_i,
   // Resolved pin controls
   output logic      [WIDTH-1:0] pin_out_o,
   output logic      [WIDTH-1:0] pin_oe_o,
   output logic      [WIDTH-1:0] pullup_o,
   output logic      [WIDTH-1:0] input_en_o
);
   genvar n;
   generate
      for (n = 0; n < WIDTH; n = n + 1)
      begin : g_bit
         logic dir;
         logic pu_norm;
         assign dir = ovr_i.dir_override_enable[n] ?
                      ovr_i.dir_override_value[n] : dir_bits_i[n];
         assign pin_oe_o[n] = dir;
         assign pin_out_o[n] = ovr_i.outval_override_enable[n] ?
                               ovr_i.outval_override_value[n] : out_bits_i[n];
         assign pu_norm = out_bits_i[n] & ~dir_bits_i[n] & ~global_pullup_disable_i;
         assign pullup_o[n] = ovr_i.pullup_override_enable[n] ?
                              ovr_i.pullup_override_value[n] : pu_norm;
         assign input_en_o[n] = ovr_i.input_en_override_enable[n] ?
                                ovr_i.input_en_override_value[n] : 1'b1;
      end
   endgenerate
endmodule : pin_override
`default_nettype wire

// ==== port_e_alt_function_mux.sv ====
// Port E and port F alternate function override mux
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_params.svh"
module port_e_alt_function_mux
   import port_mux_pkg::*;
#(
   parameter int WIDTH = `PORT_WIDTH
)
(
   // Clock, reset, enable
   input  wire logic             CLOCK_I,
   input  wire logic             RESET_I,
   input  wire logic             CLK_EN_I,
   // Port settings
   input  wire port_cfg_t        PORT_E_CFG_I,
   input  wire port_cfg_t        PORT_F_CFG_I,
   input  wire logic             GLOBAL_PULLUP_DISABLE_I,
   input  wire logic             CLOCK_OUT_FUSE_I,
   input  wire logic             DIVIDED_CLOCK_I,
   // Pin-change and comparator control
   input  wire logic [WIDTH-1:0] PINCHG_SOURCE_I,
   input  wire logic             PINCHG_GROUP0_ENABLE_I,
   input  wire logic             COMP_POS_INPUT_DISABLE_I,
   input  wire logic             COMP_NEG_INPUT_DISABLE_I,
   // Serial unit
   input  wire logic             RECEIVER_ENABLE_I,
   input  wire logic             TRANSMITTER_ENABLE_I,
   input  wire logic             TRANSMIT_DATA_I,
   input  wire logic             USART_SYNC_MODE_I,
   input  wire logic             USART_EXT_CLOCK_I,
   // Universal serial interface
   input  wire logic             TWO_WIRE_MODE_SEL_I,
   input  wire logic             THREE_WIRE_MODE_SEL_I,
   input  wire logic             SERIAL_IFACE_DATA_OUT_I,
   input  wire logic             SDA_LOW_REQ_I,
   input  wire logic             CLOCK_HOLD_LOW_I,
   input  wire logic             START_COND_INT_ENABLE_I,
   // Test access
   input  wire logic             JTAG_ENABLE_I,
   input  wire logic             JTAG_SHIFT_I,
   input  wire logic             JTAG_TDO_I,
   // Pins
   input  wire logic [WIDTH-1:0] PORT_E_PIN_I,
   input  wire logic [WIDTH-1:0] PORT_F_PIN_I,
   output logic      [WIDTH-1:0] PORT_E_OUT_O,
   output logic      [WIDTH-1:0] PORT_E_OE_O,
   output logic      [WIDTH-1:0] PORT_E_PULLUP_O,
   output logic      [WIDTH-1:0] PORT_F_OUT_O,
   output logic      [WIDTH-1:0] PORT_F_OE_O,
   output logic      [WIDTH-1:0] PORT_F_PULLUP_O,
   // Peripheral side
   output logic      [WIDTH-1:0] PINCHG_LEVEL_O,
   output logic      [WIDTH-1:0] PORT_E_IN_O,
   output logic                  USART_EXT_CLOCK_IN_O,
   output logic                  RECEIVE_DATA_O,
   output logic                  SERIAL_IFACE_DATA_IN_O,
   output logic                  SERIAL_IFACE_CLOCK_O,
   output logic                  JTAG_TDI_O,
   output logic                  JTAG_TMS_O,
   output logic                  JTAG_TCK_O
);
   override_t        ovr_e;
   override_t        ovr_f;
   logic [WIDTH-1:0] e_in_en;
   logic [WIDTH-1:0] f_in_en;
   logic [WIDTH-1:0] e_pin_out;
   logic [WIDTH-1:0] e_pin_oe;
   logic [WIDTH-1:0] e_pu;
   logic [WIDTH-1:0] f_pin_out;
   logic [WIDTH-1:0] f_pin_oe;
   logic [WIDTH-1:0] f_pu;
   logic [WIDTH-1:0] e_in_reg;
   logic [WIDTH-1:0] f_in_reg;
   logic [WIDTH-1:0] pc_en;
   logic             ext_clk_out_en;
   logic [WIDTH-1:0] test_in_pins;
   logic [WIDTH-1:0] e_out_bits;
   logic [WIDTH-1:0] e_dir_bits;

   assign e_out_bits = PORT_E_CFG_I.out_bits;
   assign e_dir_bits = PORT_E_CFG_I.dir_bits;
   assign pc_en = PINCHG_SOURCE_I & {WIDTH{PINCHG_GROUP0_ENABLE_I}};
   assign ext_clk_out_en = USART_SYNC_MODE_I & e_dir_bits[`PE_USART_CLK_BIT];

   always_comb
   begin
      ovr_e = '0;
      // Clock output; the fuse alone selects it, so reset cannot remove it
      ovr_e.dir_override_enable[`PE_CLK_OUT_BIT]   = CLOCK_OUT_FUSE_I;
      ovr_e.dir_override_value[`PE_CLK_OUT_BIT]    = 1'b1;
      ovr_e.outval_override_enable[`PE_CLK_OUT_BIT] = CLOCK_OUT_FUSE_I;
      ovr_e.outval_override_value[`PE_CLK_OUT_BIT] = DIVIDED_CLOCK_I;
      ovr_e.outval_override_enable[`PE_DO_BIT]     = THREE_WIRE_MODE_SEL_I;
      ovr_e.outval_override_value[`PE_DO_BIT]      = SERIAL_IFACE_DATA_OUT_I;
      // Two-wire open-drain: value held 0, direction carries the low
      ovr_e.pullup_override_enable[`PE_SDA_BIT]    = TWO_WIRE_MODE_SEL_I;
      ovr_e.pullup_override_enable[`PE_SCL_BIT]    = TWO_WIRE_MODE_SEL_I;
      ovr_e.dir_override_enable[`PE_SDA_BIT]       = TWO_WIRE_MODE_SEL_I;
      ovr_e.dir_override_enable[`PE_SCL_BIT]       = TWO_WIRE_MODE_SEL_I;
      ovr_e.dir_override_value[`PE_SDA_BIT]        =
         (SDA_LOW_REQ_I | e_out_bits[`PE_SDA_BIT]) & e_dir_bits[`PE_SDA_BIT];
      ovr_e.dir_override_value[`PE_SCL_BIT]        =
         (CLOCK_HOLD_LOW_I | e_out_bits[`PE_SCL_BIT]) & e_dir_bits[`PE_SCL_BIT];
      ovr_e.outval_override_enable[`PE_SDA_BIT]    =
         TWO_WIRE_MODE_SEL_I & e_dir_bits[`PE_SDA_BIT];
      ovr_e.outval_override_enable[`PE_SCL_BIT]    =
         TWO_WIRE_MODE_SEL_I & e_dir_bits[`PE_SCL_BIT];
      // Serial clock pin drives its pull-up off when it drives out
      ovr_e.pullup_override_enable[`PE_USART_CLK_BIT] = ext_clk_out_en;
      ovr_e.pullup_override_value[`PE_USART_CLK_BIT]  = 1'b0;
      ovr_e.outval_override_enable[`PE_USART_CLK_BIT] = ext_clk_out_en;
      ovr_e.outval_override_value[`PE_USART_CLK_BIT]  = USART_EXT_CLOCK_I;
      ovr_e.pullup_override_enable[`PE_TXD_BIT]    = TRANSMITTER_ENABLE_I;
      ovr_e.dir_override_enable[`PE_TXD_BIT]       = TRANSMITTER_ENABLE_I;
      ovr_e.dir_override_value[`PE_TXD_BIT]        = 1'b1;
      ovr_e.outval_override_enable[`PE_TXD_BIT]    = TRANSMITTER_ENABLE_I;
      ovr_e.outval_override_value[`PE_TXD_BIT]     = TRANSMIT_DATA_I;
      ovr_e.pullup_override_enable[`PE_RXD_BIT]    = RECEIVER_ENABLE_I;
      ovr_e.pullup_override_value[`PE_RXD_BIT]     =
         e_out_bits[`PE_RXD_BIT] & ~GLOBAL_PULLUP_DISABLE_I;
      ovr_e.dir_override_enable[`PE_RXD_BIT]       = RECEIVER_ENABLE_I;
      ovr_e.dir_override_value[`PE_RXD_BIT]        = 1'b0;
      // Digital input enables; pin-change sources keep the buffer alive
      ovr_e.input_en_override_enable = pc_en;
      ovr_e.input_en_override_value  = '1;
      ovr_e.input_en_override_enable[`PE_SDA_BIT] =
         pc_en[`PE_SDA_BIT] | START_COND_INT_ENABLE_I;
      ovr_e.input_en_override_enable[`PE_SCL_BIT] =
         pc_en[`PE_SCL_BIT] | START_COND_INT_ENABLE_I;
      ovr_e.input_en_override_enable[`PE_AIN1_BIT] =
         pc_en[`PE_AIN1_BIT] | COMP_NEG_INPUT_DISABLE_I;
      ovr_e.input_en_override_value[`PE_AIN1_BIT]  = pc_en[`PE_AIN1_BIT];
      ovr_e.input_en_override_enable[`PE_USART_CLK_BIT] =
         pc_en[`PE_USART_CLK_BIT] | COMP_POS_INPUT_DISABLE_I;
      ovr_e.input_en_override_value[`PE_USART_CLK_BIT]  = pc_en[`PE_USART_CLK_BIT];
   end

   always_comb
   begin
      ovr_f = '0;
      // Test pins reach the test port although their digital buffers are off
      test_in_pins = '0;
      test_in_pins[`PF_TDI_BIT] = JTAG_ENABLE_I;
      test_in_pins[`PF_TMS_BIT] = JTAG_ENABLE_I;
      test_in_pins[`PF_TCK_BIT] = JTAG_ENABLE_I;
      // Pull-ups tied to the enable alone so a reset does not drop them
      ovr_f.pullup_override_enable[`PF_TDI_BIT] = JTAG_ENABLE_I;
      ovr_f.pullup_override_enable[`PF_TMS_BIT] = JTAG_ENABLE_I;
      ovr_f.pullup_override_enable[`PF_TCK_BIT] = JTAG_ENABLE_I;
      ovr_f.pullup_override_enable[`PF_TDO_BIT] = JTAG_ENABLE_I;
      ovr_f.pullup_override_value[`PF_TDI_BIT]  = 1'b1;
      ovr_f.pullup_override_value[`PF_TMS_BIT]  = 1'b1;
      ovr_f.pullup_override_value[`PF_TCK_BIT]  = 1'b1;
      ovr_f.pullup_override_value[`PF_TDO_BIT]  = 1'b1;
      ovr_f.dir_override_enable[`PF_TDI_BIT]    = JTAG_ENABLE_I;
      ovr_f.dir_override_enable[`PF_TMS_BIT]    = JTAG_ENABLE_I;
      ovr_f.dir_override_enable[`PF_TCK_BIT]    = JTAG_ENABLE_I;
      ovr_f.dir_override_enable[`PF_TDO_BIT]    = JTAG_ENABLE_I;
      ovr_f.dir_override_value[`PF_TDO_BIT]     = JTAG_SHIFT_I;
      ovr_f.outval_override_enable[`PF_TDO_BIT] = JTAG_ENABLE_I;
      ovr_f.outval_override_value[`PF_TDO_BIT]  = JTAG_TDO_I;
      ovr_f.input_en_override_enable[`PF_TDI_BIT] = JTAG_ENABLE_I;
      ovr_f.input_en_override_enable[`PF_TMS_BIT] = JTAG_ENABLE_I;
      ovr_f.input_en_override_enable[`PF_TCK_BIT] = JTAG_ENABLE_I;
      ovr_f.input_en_override_enable[`PF_TDO_BIT] = JTAG_ENABLE_I;
   end

   pin_override #(.WIDTH(WIDTH)) u_port_e
   (
      .out_bits_i              (e_out_bits),
      .dir_bits_i              (e_dir_bits),
      .global_pullup_disable_i (GLOBAL_PULLUP_DISABLE_I),
      .ovr_i                   (ovr_e),
      .pin_out_o               (e_pin_out),
      .pin_oe_o                (e_pin_oe),
      .pullup_o                (e_pu),
      .input_en_o              (e_in_en)
   );

   pin_override #(.WIDTH(WIDTH)) u_port_f
   (
      .out_bits_i              (PORT_F_CFG_I.out_bits),
      .dir_bits_i              (PORT_F_CFG_I.dir_bits),
      .global_pullup_disable_i (GLOBAL_PULLUP_DISABLE_I),
      .ovr_i                   (ovr_f),
      .pin_out_o               (f_pin_out),
      .pin_oe_o                (f_pin_oe),
      .pullup_o                (f_pu),
      .input_en_o              (f_in_en)
   );

   // Pin drive is combinational so the clock output is not delayed
   assign PORT_E_OUT_O    = e_pin_out;
   assign PORT_E_OE_O     = e_pin_oe;
   assign PORT_E_PULLUP_O = e_pu;
   assign PORT_F_OUT_O    = f_pin_out;
   assign PORT_F_OE_O     = f_pin_oe;
   assign PORT_F_PULLUP_O = f_pu;

   // Input sampling; a disabled buffer reads as zero, except the port F test input pins
   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
         e_in_reg <= `CLK_DIV_RESET;
      else if (CLK_EN_I)
         e_in_reg <= PORT_E_PIN_I & e_in_en;
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
         f_in_reg <= `CLK_DIV_RESET;
      else if (CLK_EN_I)
         f_in_reg <= PORT_F_PIN_I & (f_in_en | test_in_pins);
   end

   assign PORT_E_IN_O            = e_in_reg;
   assign PINCHG_LEVEL_O         = e_in_reg;
   assign RECEIVE_DATA_O         = e_in_reg[`PE_RXD_BIT];
   assign USART_EXT_CLOCK_IN_O   =
      e_in_reg[`PE_USART_CLK_BIT] & ~e_dir_bits[`PE_USART_CLK_BIT];
   assign SERIAL_IFACE_DATA_IN_O = e_in_reg[`PE_SDA_BIT];
   assign SERIAL_IFACE_CLOCK_O   = e_in_reg[`PE_SCL_BIT];
   assign JTAG_TDI_O             = f_in_reg[`PF_TDI_BIT] & JTAG_ENABLE_I;
   assign JTAG_TMS_O             = f_in_reg[`PF_TMS_BIT] & JTAG_ENABLE_I;
   assign JTAG_TCK_O             = f_in_reg[`PF_TCK_BIT] & JTAG_ENABLE_I;

   property p_clk_drive;
      @(posedge CLOCK_I) disable iff (RESET_I)
      CLOCK_OUT_FUSE_I |-> PORT_E_OE_O[`PE_CLK_OUT_BIT] &&
         PORT_E_OUT_O[`PE_CLK_OUT_BIT] == DIVIDED_CLOCK_I;
   endproperty
   a_clk_drive: assert property (p_clk_drive) else $error("clock pin not driven");

   property p_clk_reset;
      @(posedge CLOCK_I) (RESET_I && CLOCK_OUT_FUSE_I) |->
         PORT_E_OUT_O[`PE_CLK_OUT_BIT] == DIVIDED_CLOCK_I;
   endproperty
   a_clk_reset: assert property (p_clk_reset) else $error("clock lost in reset");

   property p_rx_input;
      @(posedge CLOCK_I) disable iff (RESET_I)
      RECEIVER_ENABLE_I |-> !PORT_E_OE_O[`PE_RXD_BIT] &&
         PORT_E_PULLUP_O[`PE_RXD_BIT] ==
         (e_out_bits[`PE_RXD_BIT] && !GLOBAL_PULLUP_DISABLE_I);
   endproperty
   a_rx_input: assert property (p_rx_input) else $error("receive pin wrong");

   property p_tx_out;
      @(posedge CLOCK_I) disable iff (RESET_I)
      TRANSMITTER_ENABLE_I |-> PORT_E_OE_O[`PE_TXD_BIT] && !PORT_E_PULLUP_O[`PE_TXD_BIT]
         && PORT_E_OUT_O[`PE_TXD_BIT] == TRANSMIT_DATA_I;
   endproperty
   a_tx_out: assert property (p_tx_out) else $error("transmit pin wrong");

   property p_twi_low;
      @(posedge CLOCK_I) disable iff (RESET_I)
      (TWO_WIRE_MODE_SEL_I && e_dir_bits[`PE_SCL_BIT]) |->
         !PORT_E_OUT_O[`PE_SCL_BIT] && !PORT_E_PULLUP_O[`PE_SCL_BIT] &&
         PORT_E_OE_O[`PE_SCL_BIT] == (CLOCK_HOLD_LOW_I || e_out_bits[`PE_SCL_BIT]);
   endproperty
   a_twi_low: assert property (p_twi_low) else $error("two-wire clock wrong");

   property p_do_out;
      @(posedge CLOCK_I) disable iff (RESET_I)
      THREE_WIRE_MODE_SEL_I |-> PORT_E_OUT_O[`PE_DO_BIT] == SERIAL_IFACE_DATA_OUT_I;
   endproperty
   a_do_out: assert property (p_do_out) else $error("data out wrong");

   property p_jtag_pu;
      @(posedge CLOCK_I) JTAG_ENABLE_I |->
         PORT_F_PULLUP_O[`PF_TDI_BIT] && PORT_F_PULLUP_O[`PF_TMS_BIT] &&
         PORT_F_PULLUP_O[`PF_TCK_BIT];
   endproperty
   a_jtag_pu: assert property (p_jtag_pu) else $error("test pull-up off");

   property p_pinchg;
      @(posedge CLOCK_I) disable iff (RESET_I)
      (CLK_EN_I && PINCHG_SOURCE_I[0] && PINCHG_GROUP0_ENABLE_I) ##1 1'b1 |->
         PINCHG_LEVEL_O[0] == $past(PORT_E_PIN_I[0]);
   endproperty
   a_pinchg: assert property (p_pinchg) else $error("pin-change level lost");
endmodule : port_e_alt_function_mux
`default_nettype wire

// ==== pin_world.sv ====
// External pin model: resolves device drivers, far-side drivers and pull-ups
`timescale 1ns/1ps
`default_nettype none
module pin_world
(
   // Clock
   input  wire logic       clock_i,
   // Device side
   input  wire logic [7:0] out_i,
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] pullup_i,
   // Far-side driver
   input  wire logic [7:0] ext_val_i,
   input  wire logic [7:0] ext_en_i,
   // Resolved pin levels
   output logic      [7:0] pin_o
);
   logic [7:0] float_reg = 8'h5a;
   // A line nobody holds must not look stable, so it changes every cycle
   always @(posedge clock_i)
   begin
      float_reg <= ~float_reg;
   end
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (oe_i[i])
            pin_o[i] = out_i[i];
         else if (ext_en_i[i])
            pin_o[i] = ext_val_i[i];
         else if (pullup_i[i])
            pin_o[i] = 1'b1;
         else
            pin_o[i] = float_reg[i];
      end
   end
endmodule : pin_world
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the port E and port F override mux
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp, msg) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("MISMATCH %0t %s", $time, msg); \
      end \
   end
module testbench
   import port_mux_pkg::*;
   ;
   logic            clk, rst, en, pu_dis, fuse, dclk, grp, rx, tx, txd, sync, uclk;
   logic            two, three, dout, sda_req, hold, jt, jshift, jtdo;
   port_cfg_t       e_cfg, f_cfg;
   logic      [7:0] src, e_ext, e_ext_en, f_ext, f_ext_en;
   wire logic [7:0] e_pin, f_pin, e_out, e_oe, e_pu, f_out, f_oe, f_pu, pc_lvl, e_in;
   wire logic       tdi, tms, tck, rx_in, uclk_in, si_din, si_clk;
   int              err_total, n_tests;

   port_e_alt_function_mux uut (
      .CLOCK_I(clk), .RESET_I(rst), .CLK_EN_I(en),
      .PORT_E_CFG_I(e_cfg), .PORT_F_CFG_I(f_cfg), .GLOBAL_PULLUP_DISABLE_I(pu_dis),
      .CLOCK_OUT_FUSE_I(fuse), .DIVIDED_CLOCK_I(dclk), .PINCHG_SOURCE_I(src),
      .PINCHG_GROUP0_ENABLE_I(grp), .COMP_POS_INPUT_DISABLE_I(1'b0),
      .COMP_NEG_INPUT_DISABLE_I(1'b0), .RECEIVER_ENABLE_I(rx), .TRANSMITTER_ENABLE_I(tx),
      .TRANSMIT_DATA_I(txd), .USART_SYNC_MODE_I(sync), .USART_EXT_CLOCK_I(uclk),
      .TWO_WIRE_MODE_SEL_I(two), .THREE_WIRE_MODE_SEL_I(three),
      .SERIAL_IFACE_DATA_OUT_I(dout), .SDA_LOW_REQ_I(sda_req), .CLOCK_HOLD_LOW_I(hold),
      .START_COND_INT_ENABLE_I(1'b0), .JTAG_ENABLE_I(jt), .JTAG_SHIFT_I(jshift),
      .JTAG_TDO_I(jtdo), .PORT_E_PIN_I(e_pin), .PORT_F_PIN_I(f_pin),
      .PORT_E_OUT_O(e_out), .PORT_E_OE_O(e_oe), .PORT_E_PULLUP_O(e_pu),
      .PORT_F_OUT_O(f_out), .PORT_F_OE_O(f_oe), .PORT_F_PULLUP_O(f_pu),
      .PINCHG_LEVEL_O(pc_lvl), .PORT_E_IN_O(e_in), .USART_EXT_CLOCK_IN_O(uclk_in),
      .RECEIVE_DATA_O(rx_in), .SERIAL_IFACE_DATA_IN_O(si_din), .SERIAL_IFACE_CLOCK_O(si_clk),
      .JTAG_TDI_O(tdi), .JTAG_TMS_O(tms), .JTAG_TCK_O(tck));
   pin_world pins_e (.clock_i(clk), .out_i(e_out), .oe_i(e_oe), .pullup_i(e_pu),
      .ext_val_i(e_ext), .ext_en_i(e_ext_en), .pin_o(e_pin));
   pin_world pins_f (.clock_i(clk), .out_i(f_out), .oe_i(f_oe), .pullup_i(f_pu),
      .ext_val_i(f_ext), .ext_en_i(f_ext_en), .pin_o(f_pin));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task report_and_stop;
      if (err_total == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // Inputs move a fixed 2 ns after the rising edge
   task step;
      @(posedge clk);
      #2;
   endtask : step

   task idle;
      {en, pu_dis, fuse, dclk, grp, rx, tx, txd, sync, uclk} = 10'h200;
      {two, three, dout, sda_req, hold, jt, jshift, jtdo} = 8'h00;
      e_cfg = '0;
      f_cfg = '0;
      src = 8'h00;
      {e_ext, e_ext_en, f_ext, f_ext_en} = 32'h0;
      step();
   endtask : idle

   task t_clock_out;
      idle();
      fuse = 1'b1;
      dclk = 1'b1;
      step();
      `CHECK(e_oe[7], 1'b1, "clock pin not output")
      `CHECK(e_out[7], 1'b1, "clock pin high phase")
      dclk = 1'b0;
      e_cfg.out_bits = 8'h80;
      step();
      `CHECK(e_out[7], 1'b0, "clock pin took port bit")
      fuse = 1'b0;
      step();
      `CHECK({e_oe[7], e_out[7]}, 2'b01, "clock override stuck")
   endtask : t_clock_out

   // Reset in mid-run with the clock fuse and test access on
   task t_reset;
      idle();
      fuse = 1'b1;
      jt = 1'b1;
      dclk = 1'b1;
      rst = 1'b1;
      step();
      `CHECK(e_out[7] & e_oe[7], 1'b1, "clock lost in reset")
      `CHECK(f_pu & 8'hb0, 8'hb0, "test pull-ups off in reset")
      `CHECK(pc_lvl, 8'h00, "samples not cleared in reset")
      dclk = 1'b0;
      step();
      `CHECK(e_out[7], 1'b0, "clock frozen in reset")
      rst = 1'b0;
   endtask : t_reset

   task t_serial;
      idle();
      rx = 1'b1;
      e_cfg.dir_bits = 8'h01;
      e_cfg.out_bits = 8'h03;
      step();
      `CHECK(e_oe[0], 1'b0, "receiver pin drives")
      `CHECK(e_pu[0], 1'b1, "receiver pull-up off")
      pu_dis = 1'b1;
      step();
      `CHECK(e_pu[0], 1'b0, "pull-up ignores global disable")
      tx = 1'b1;
      step();
      `CHECK({e_oe[1], e_out[1], e_pu[1]}, 3'b100, "transmit pin low")
      txd = 1'b1;
      step();
      `CHECK(e_out[1], 1'b1, "transmit pin high")
   endtask : t_serial

   task t_sync_clock;
      idle();
      sync = 1'b1;
      uclk = 1'b1;
      e_cfg.dir_bits = 8'h04;
      step();
      `CHECK({e_oe[2], e_out[2]}, 2'b11, "serial clock not out")
      uclk = 1'b0;
      e_cfg.out_bits = 8'h04;
      step();
      `CHECK(e_out[2], 1'b0, "serial clock value")
      sync = 1'b0;
      step();
      `CHECK(e_out[2], 1'b1, "serial clock outside sync mode")
      sync = 1'b1;
      e_cfg.dir_bits = 8'h00;
      step();
      `CHECK(e_oe[2], 1'b0, "serial clock in drives")
   endtask : t_sync_clock

   task t_two_wire;
      idle();
      two = 1'b1;
      e_cfg.out_bits = 8'h30;
      step();
      `CHECK(e_pu[5:4], 2'b00, "two-wire pull-ups on")
      e_cfg.out_bits = 8'h00;
      e_cfg.dir_bits = 8'h30;
      step();
      `CHECK(e_oe[5:4], 2'b00, "two-wire pins drive unasked")
      sda_req = 1'b1;
      step();
      `CHECK({e_oe[5:4], e_out[5]}, 3'b100, "data line not pulled low")
      hold = 1'b1;
      step();
      `CHECK({e_oe[4], e_out[4]}, 2'b10, "clock line not held low")
      {sda_req, hold} = 2'b00;
      e_cfg.out_bits = 8'h30;
      step();
      `CHECK({e_oe[5:4], e_out[5:4]}, 4'hc, "port bits not low")
   endtask : t_two_wire

   task t_three_wire;
      idle();
      three = 1'b1;
      dout = 1'b1;
      step();
      `CHECK(e_out[6], 1'b1, "data-out high")
      dout = 1'b0;
      step();
      `CHECK(e_out[6], 1'b0, "data-out low")
   endtask : t_three_wire

   task t_pinchg;
      idle();
      src = 8'hff;
      grp = 1'b1;
      three = 1'b1;
      e_ext_en = 8'hff;
      e_ext = 8'ha5;
      step();
      `CHECK(pc_lvl, 8'ha5, "pin-change levels")
      `CHECK(e_in, 8'ha5, "port input sample")
      `CHECK({rx_in, uclk_in, si_din, si_clk}, 4'b1110, "peripheral inputs")
      en = 1'b0;
      e_ext = 8'h5a;
      step();
      `CHECK(pc_lvl, 8'ha5, "samples moved while frozen")
      en = 1'b1;
      step();
      `CHECK(pc_lvl, 8'h5a, "pin-change levels")
   endtask : t_pinchg

   task t_jtag;
      idle();
      jt = 1'b1;
      f_cfg.dir_bits = 8'hff;
      // All port F direction bits are set; test access must still override bits 4 to 7
      step();
      `CHECK(f_pu & 8'hb0, 8'hb0, "test pull-ups off")
      `CHECK(f_oe[7], 1'b0, "test data pin drives")
      {jshift, jtdo} = 2'b11;
      step();
      `CHECK({f_oe[6], f_out[6]}, 2'b11, "test data out")
      f_ext_en = 8'hb0;
      f_ext = 8'hb0;
      step();
      `CHECK({tdi, tms, tck}, 3'b111, "test pins in high")
      f_ext = 8'h00;
      step();
      `CHECK({tdi, tms, tck}, 3'b000, "test pins in low")
   endtask : t_jtag

   initial
   begin
      #200us;
      err_total++;
      report_and_stop();
   end

   initial
   begin
      err_total = 0;
      n_tests = 0;
      rst = 1'b1;
      idle();
      repeat (2) @(posedge clk);
      #2;
      rst = 1'b0;
      t_clock_out();
      t_reset();
      t_serial();
      t_sync_clock();
      t_two_wire();
      t_three_wire();
      t_pinchg();
      t_jtag();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
